/* File: include/regulator_pkg.sv */
package regulator_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 8;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CLEAR   = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ENABLE  = 4'h3;
  localparam int unsigned BIT_FLAG   = 0;
  localparam int unsigned BIT_IE     = 1;
  localparam int unsigned BIT_STATUS = 2;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam int unsigned EVT_W = 1;
  localparam logic [EVT_W-1:0] EVT_RESET = 1'h0;

  // ------------------------------------------------------------
  // operating modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FULL_PERFORMANCE,
    REDUCED_POWER,
    SHUTDOWN
  } reg_mode_t;
endpackage

/* File: include/detect_if.sv */
interface detect_if;
  import regulator_pkg::*;
  logic      lowRaw;
  reg_mode_t mode;
  logic      lowStatus;
  logic      changed;
  modport mgr (input lowRaw, input mode, output lowStatus, output changed);
  modport top (output lowRaw, output mode, input lowStatus, input changed);
endinterface

/* File: verilog/mode_select.sv */
module mode_select
  import regulator_pkg::*;
(
  input  wire logic      stopMode,
  input  wire logic      regulatorEnablePin,
  output reg_mode_t      mode
);
  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  always_comb
  begin
    if (!regulatorEnablePin)
      mode = SHUTDOWN;          // [R8]
    else if (stopMode)
      mode = REDUCED_POWER;     // [R7] [R9]
    else
      mode = FULL_PERFORMANCE;  // [R6] [R9]
  end
endmodule // mode_select

/* File: verilog/low_voltage_status.sv */
module low_voltage_status
(
  input wire logic clk,
  input wire logic rst_n,
  detect_if.mgr    det
);
  import regulator_pkg::*;
  logic next_lowStatus;
  logic lowStatus;

  // ------------------------------------------------------------
  // status follows detector only in full performance
  // ------------------------------------------------------------
  always_comb
  begin
    next_lowStatus = det.lowRaw && (det.mode == FULL_PERFORMANCE); // [R1]
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lowStatus <= 1'b0;
    else
      lowStatus <= next_lowStatus;
  end

  assign det.lowStatus = lowStatus;
  // change in either direction, also on mode-forced drop
  assign det.changed   = lowStatus != next_lowStatus; // [R2]
endmodule // low_voltage_status

/* File: verilog/regulator_mode_and_low_voltage_flags.sv */
// What this block does
// R1 - The read-only status bit 2 shows low input voltage only in full performance, else 0.
// R2 - The interrupt flag bit 0 is set whenever the status bit changes either way.
// R3 - The flag clears only on a write of one; a write of zero is ignored.
// R4 - With enable bit 1 set a set flag requests an interrupt; cleared, none.
// R5 - Entering reduced power never clears the flag.
// R6 - Not in stop with the regulator enabled gives full performance with all detectors.
// R7 - Stop mode gives reduced power, with only power-on reset kept.
// R8 - A low regulator enable pin selects shutdown with outputs off and only power-on reset.
// R9 - With the enable pin high the mode is full performance or reduced power, never shutdown.
// R10 - Power-on reset stays enabled in every mode.
// R11 - The system does not toggle the enable pin between shutdown and active while powered.
// R12 - The interrupt output is the level AND of flag and enable; here that AND is registered, so the output follows one cycle later.
//
// Our own choice: the plain strobed port.
module regulator_mode_and_low_voltage_flags
(
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [regulator_pkg::ADDR_W-1:0] addr,
  input  wire logic [regulator_pkg::DATA_W-1:0] wrData,
  input  wire logic                          wrStrobe,
  input  wire logic                          rdStrobe,
  output logic      [regulator_pkg::DATA_W-1:0] rdData,
  input  wire logic                          stopMode,
  input  wire logic                          regulatorEnablePin,
  input  wire logic                          lowVoltageDetectorRaw,
  output logic                               lowVoltageDetectorEnable,
  output logic                               lowVoltageResetEnable,
  output logic                               powerOnResetEnable,
  output logic                               regulatorOutputEnable,
  output logic                               reducedPowerMode,
  output logic                               lowVoltageInterrupt
);
  import regulator_pkg::*;

  reg_mode_t mode;
  logic      lowVoltageIrqFlag;
  logic      lowVoltageIrqEnable;
  logic      clearHit;
  logic      flagClear;
  detect_if  det();

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  mode_select u_mode (
    .stopMode           (stopMode),
    .regulatorEnablePin (regulatorEnablePin), // [R11] pin assumed static while powered
    .mode               (mode)
  );

  assign det.lowRaw = lowVoltageDetectorRaw;
  assign det.mode   = mode;

  low_voltage_status u_status (
    .clk   (clk),
    .rst_n (rst_n),
    .det   (det)
  );

  // ------------------------------------------------------------
  // feature enables per mode
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lowVoltageDetectorEnable <= 1'b0;
      lowVoltageResetEnable    <= 1'b0;
      powerOnResetEnable       <= 1'b1;
      regulatorOutputEnable    <= 1'b0;
      reducedPowerMode         <= 1'b0;
    end
    else
    begin
      lowVoltageDetectorEnable <= (mode == FULL_PERFORMANCE); // [R6] [R7] [R8]
      lowVoltageResetEnable    <= (mode == FULL_PERFORMANCE); // [R6] [R7] [R8]
      powerOnResetEnable       <= 1'b1;                       // [R10]
      regulatorOutputEnable    <= (mode != SHUTDOWN);         // [R8]
      reducedPowerMode         <= (mode == REDUCED_POWER);    // [R7]
    end
  end

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  function automatic logic clearsFlag(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    clearsFlag = ((a == REG_CONTROL) || (a == REG_CLEAR)) && d[BIT_FLAG];
  endfunction

  assign clearHit  = wrStrobe && clearsFlag(addr, wrData); // [R3]
  assign flagClear = clearHit;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lowVoltageIrqEnable <= 1'b0;
    else if (wrStrobe && (addr == REG_CONTROL))
      lowVoltageIrqEnable <= wrData[BIT_IE];
    // enable register shares the status layout, so its bit sits at 0
    else if (wrStrobe && (addr == REG_ENABLE))
      lowVoltageIrqEnable <= wrData[BIT_FLAG]; // [R4]
  end

  // ------------------------------------------------------------
  // sticky flag; set beats clear, mode entry never clears
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lowVoltageIrqFlag <= EVT_RESET;
    else if (det.changed)
      lowVoltageIrqFlag <= 1'b1; // [R2] [R5]
    else if (flagClear)
      lowVoltageIrqFlag <= 1'b0; // [R3]
  end

  // ------------------------------------------------------------
  // interrupt output, registered so it lags the flag one cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lowVoltageInterrupt <= 1'b0;
    else
      lowVoltageInterrupt <= next_irq(lowVoltageIrqFlag, lowVoltageIrqEnable); // [R4] [R12]
  end

  function automatic logic next_irq(input logic f, input logic e);
    next_irq = f && e;
  endfunction

  // ------------------------------------------------------------
  // read path, data one cycle after strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdData <= READ_ZERO;
    else if (rdStrobe)
    begin
      rdData <= READ_ZERO;
      unique case (addr)
        REG_CONTROL:
        begin
          rdData[BIT_STATUS] <= det.lowStatus; // [R1]
          rdData[BIT_IE]     <= lowVoltageIrqEnable;
          rdData[BIT_FLAG]   <= lowVoltageIrqFlag;
        end
        REG_STATUS:
          rdData[BIT_FLAG] <= lowVoltageIrqFlag;
        REG_ENABLE:
          rdData[BIT_FLAG] <= lowVoltageIrqEnable;
        default:
          rdData <= READ_ZERO; // write-only clear and unmapped read zero
      endcase
    end
    else
      rdData <= READ_ZERO;
  end
endmodule // regulator_mode_and_low_voltage_flags

/* File: dv/regulator_sva.sv */
module regulator_sva
  import regulator_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic              wrStrobe,
  input wire logic              rdStrobe,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic              stopMode,
  input wire logic              regulatorEnablePin,
  input wire logic              lowVoltageDetectorRaw,
  input wire logic              lowVoltageDetectorEnable,
  input wire logic              lowVoltageResetEnable,
  input wire logic              powerOnResetEnable,
  input wire logic              regulatorOutputEnable,
  input wire logic              reducedPowerMode,
  input wire logic              lowVoltageInterrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_por_always: assert property (powerOnResetEnable)
    else $error("por enable low");
  a_shutdown_off: assert property ($past(rst_n) && !$past(regulatorEnablePin)
    |-> !regulatorOutputEnable && !lowVoltageDetectorEnable && !lowVoltageResetEnable)
    else $error("shutdown outputs on");
  a_full_perf: assert property ($past(rst_n) && $past(regulatorEnablePin && !stopMode)
    |-> lowVoltageDetectorEnable && lowVoltageResetEnable && !reducedPowerMode)
    else $error("full mode wrong");
  a_reduced_power: assert property ($past(rst_n) && $past(regulatorEnablePin && stopMode)
    |-> reducedPowerMode && regulatorOutputEnable && !lowVoltageDetectorEnable)
    else $error("reduced mode wrong");
  a_status_ro: assert property (rdStrobe && addr == REG_CONTROL && stopMode
    && $past(stopMode) && $past(stopMode, 2) |=> !rdData[BIT_STATUS])
    else $error("status set in stop");
  a_clear_drops_irq: assert property ((wrStrobe && addr == REG_CONTROL && wrData[BIT_FLAG]
    && $stable(lowVoltageDetectorRaw) && $stable(stopMode)) ##1
    ($stable(lowVoltageDetectorRaw) && $stable(stopMode)) |=> !lowVoltageInterrupt)
    else $error("irq kept after clear");
  a_disable_quiet: assert property (wrStrobe && addr == REG_ENABLE && !wrData[BIT_FLAG]
    |-> ##2 !lowVoltageInterrupt)
    else $error("irq while disabled");
  a_irq_holds: assert property (lowVoltageInterrupt && !$past(wrStrobe)
    |=> lowVoltageInterrupt)
    else $error("irq dropped alone");
endmodule // regulator_sva

/* File: dv/power_mode_model.sv */
module power_mode_model
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic wantStop,
  input  wire logic wantPin,
  output logic      stopMode = 1'b0,
  output logic      regulatorEnablePin = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin moves only while the core is held in reset
  always @(posedge clk) if (!rst_n) regulatorEnablePin <= wantPin;
  always @(posedge clk) stopMode <= wantStop;
endmodule // power_mode_model

/* File: dv/tb_regulator_mode_and_low_voltage_flags.sv */
module tb_regulator_mode_and_low_voltage_flags;
  timeunit 1ns;
  timeprecision 1ps;
  import regulator_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              wrStrobe = 1'b0;
  logic              rdStrobe = 1'b0;
  logic              raw = 1'b0;
  logic              wantStop = 1'b0;
  logic              wantPin = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wrData = 8'h00;
  logic [DATA_W-1:0] rdData;
  logic              stopMode, pin, lvdEn, lvrEn, porEn, outEn, reduced_power_mode, irq;
  int                errors = 0;
  int                n_tests = 0;
  always #2 clk = ~clk;
  power_mode_model pm (.clk(clk), .rst_n(rst_n), .wantStop(wantStop), .wantPin(wantPin),
    .stopMode(stopMode), .regulatorEnablePin(pin));
  regulator_mode_and_low_voltage_flags dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .stopMode(stopMode), .regulatorEnablePin(pin), .lowVoltageDetectorRaw(raw),
    .lowVoltageDetectorEnable(lvdEn), .lowVoltageResetEnable(lvrEn),
    .powerOnResetEnable(porEn), .regulatorOutputEnable(outEn),
    .reducedPowerMode(reduced_power_mode), .lowVoltageInterrupt(irq));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a; wrData <= d; wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a; rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 chk(rdData, e);
  endtask
  task boot(input logic p);
    @(posedge clk);
    rst_n <= 1'b0;
    wantPin <= p;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // tests need about 70 cycles; the 5000-cycle limit leaves ample margin
  initial
  begin
    #20000;
    errors++;
    wrap_up;
  end
  initial
  begin
    raw <= 1'b1;
    boot(1'b0);
    rd(REG_CONTROL, 8'h00);
    chk({6'h00, outEn, porEn}, 8'h01);
    boot(1'b1);
    rd(REG_CONTROL, 8'h05);
    chk({7'h00, irq}, 8'h00);
    wr(REG_CONTROL, 8'h02);
    rd(REG_CONTROL, 8'h07);
    chk({7'h00, irq}, 8'h01);
    wr(REG_CONTROL, 8'h03);
    rd(REG_CONTROL, 8'h06);
    @(posedge clk);
    raw <= 1'b0;
    rd(REG_CONTROL, 8'h03);
    rd(REG_STATUS, 8'h01);
    rd(4'hF, READ_ZERO);
    @(posedge clk);
    wantStop <= 1'b1;
    rd(REG_CONTROL, 8'h03);
    chk({5'h00, reduced_power_mode, lvdEn, lvrEn}, 8'h04);
    wr(REG_CLEAR, 8'h01);
    @(posedge clk);
    raw <= 1'b1;
    rd(REG_CONTROL, 8'h02);
    rd(REG_ENABLE, 8'h01);
    wr(REG_ENABLE, 8'h00);
    @(posedge clk);
    wantStop <= 1'b0;
    repeat (3) @(posedge clk);
    rd(REG_CONTROL, 8'h05);
    chk({7'h00, irq}, 8'h00);
    wr(REG_ENABLE, 8'h01);
    rd(REG_CONTROL, 8'h07);
    chk({7'h00, irq}, 8'h01);
    wrap_up;
  end
endmodule // tb_regulator_mode_and_low_voltage_flags
bind regulator_mode_and_low_voltage_flags regulator_sva chk (
  .clk                      (clk),
  .rst_n                    (rst_n),
  .addr                     (addr),
  .wrData                   (wrData),
  .wrStrobe                 (wrStrobe),
  .rdStrobe                 (rdStrobe),
  .rdData                   (rdData),
  .stopMode                 (stopMode),
  .regulatorEnablePin       (regulatorEnablePin),
  .lowVoltageDetectorRaw    (lowVoltageDetectorRaw),
  .lowVoltageDetectorEnable (lowVoltageDetectorEnable),
  .lowVoltageResetEnable    (lowVoltageResetEnable),
  .powerOnResetEnable       (powerOnResetEnable),
  .regulatorOutputEnable    (regulatorOutputEnable),
  .reducedPowerMode         (reducedPowerMode),
  .lowVoltageInterrupt      (lowVoltageInterrupt)
);
